/* File: shared/cis_pkg.sv */
`default_nettype none
package cis_pkg;

  // ************************************************************
  // widths and counts
  // ************************************************************
  localparam int unsigned NUM_SRC = 8;
  localparam int unsigned PC_W = 16;
  localparam int unsigned SP_W = 16;
  localparam int unsigned VEC_STEP = 2;
  localparam int unsigned PC_BYTES = 3;
  localparam int unsigned ENTRY_CYCLES = 5;
  localparam int unsigned RETURN_CYCLES = 5;
  localparam int unsigned WAKE_EXTRA_CYCLES = 5;
  localparam logic [PC_W-1:0] BOOT_START_DEF = 16'hf000;

  // ************************************************************
  // register offsets and fields
  // ************************************************************
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_PROC_CTRL = 4'h1;
  localparam logic [3:0] REG_ENABLE = 4'h2;
  localparam logic [3:0] REG_FLAGS = 4'h3;
  localparam logic [3:0] REG_SP_LO = 4'h4;
  localparam logic [3:0] REG_SP_HI = 4'h5;
  localparam logic [3:0] REG_STATE = 4'h6;
  localparam int unsigned GIE_BIT = 7;
  localparam int unsigned RELOC_BIT = 1;
  localparam logic [SP_W-1:0] SP_RESET = 16'h10ff;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAKE = 2'b01,
    ST_ENTRY = 2'b10,
    ST_RETURN = 2'b11
  } cis_state_t;

endpackage
`default_nettype wire

/* File: hw/cis_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer
  import cis_pkg::*;
#(
  parameter int unsigned N_SRC = cis_pkg::NUM_SRC,
  parameter logic [cis_pkg::PC_W-1:0] BOOT_START = cis_pkg::BOOT_START_DEF,
  parameter logic [N_SRC-1:0] LEVEL_TYPE = '0
) (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // interrupt sources, events are one-cycle pulses, levels are held
  input wire logic [N_SRC-1:0] src_event,
  // core pipeline
  input wire logic insn_boundary,
  input wire logic insn_cli,
  input wire logic insn_sei,
  input wire logic insn_return_from_interrupt,
  input wire logic core_sleeping,
  input wire logic wake_ready,
  input wire logic [cis_pkg::PC_W-1:0] program_counter,
  input wire logic [cis_pkg::PC_W-1:0] boot_section_start,
  // fuses and lock bits
  input wire logic boot_reset_vector_fuse,
  input wire logic app_section_lock_bit,
  input wire logic boot_section_lock_bit,
  // towards the core
  output logic core_stall,
  output logic vector_valid,
  output logic [cis_pkg::PC_W-1:0] vector_addr,
  output logic [7:0] vector_index,
  output logic stack_wr,
  output logic stack_rd,
  output logic [cis_pkg::SP_W-1:0] stack_addr,
  output logic [7:0] stack_wdata,
  input wire logic [7:0] stack_rdata,
  output logic pc_load,
  output logic [cis_pkg::PC_W-1:0] pc_load_value
);
  import cis_pkg::*;

  // elaboration check: the index and register fields hold at most 8 sources
  if (N_SRC < 1 || N_SRC > 8) begin : g_bad_src
    $error("source count must be 1 to 8");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    cis_state_t st;
    logic [2:0] cnt;
    logic gie;
    logic vector_relocate_select;
    logic [N_SRC-1:0] en;
    logic [N_SRC-1:0] flg;
    logic [SP_W-1:0] sp;
    logic [PC_W-1:0] ret_pc;
    logic [7:0] idx;
    logic hold_one;
    logic reset_vec;
    logic [7:0] rdata;
    logic [PC_W-1:0] vaddr;
    logic vvalid;
    logic [PC_W-1:0] popped;
  } cis_regs_t;

  cis_regs_t q, d;

  logic [N_SRC-1:0] req;
  logic any_req;
  logic [7:0] win;
  logic locked;
  logic in_boot;
  logic can_take;
  logic [PC_W-1:0] vec_base;

  // ************************************************************
  // request merge and arbitration
  // ************************************************************
  // level sources bypass the flag, flag sources use the sticky flag
  genvar g;
  generate
    for (g = 0; g < N_SRC; g++) begin : g_req
      assign req[g] = q.en[g] &&
        (LEVEL_TYPE[g] ? src_event[g] : q.flg[g]);
    end
  endgenerate

  // lowest index is lowest vector address, so highest priority
  always_comb begin
    win = 8'h00;
    any_req = 1'b0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        win = 8'(i + 1); // index 0 is reset
        any_req = 1'b1;
      end
    end
  end

  // lock bits block interrupts in the section that they protect
  assign in_boot = program_counter >= boot_section_start;
  assign locked = in_boot ? boot_section_lock_bit
                          : app_section_lock_bit;

  // cli of this cycle wins over any request; sei/return_from_interrupt delay by one insn
  assign can_take = q.st == ST_RUN && insn_boundary && any_req &&
    q.gie && !insn_cli && !locked && !q.hold_one &&
    !insn_sei && !insn_return_from_interrupt;

  assign vec_base = q.vector_relocate_select ? boot_section_start : '0;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    d.vvalid = 1'b0;
    // events set flags; set wins over a same-cycle register clear, not over the clear when the source is taken
    if (reg_wr && reg_addr == REG_FLAGS) begin
      d.flg = q.flg & ~reg_wdata[N_SRC-1:0];
    end
    d.flg = d.flg | (src_event & ~LEVEL_TYPE);
    if (reg_wr) begin
      case (reg_addr)
        REG_STATUS: d.gie = reg_wdata[GIE_BIT];
        REG_PROC_CTRL: d.vector_relocate_select = reg_wdata[RELOC_BIT];
        REG_ENABLE: d.en = reg_wdata[N_SRC-1:0];
        REG_SP_LO: d.sp[7:0] = reg_wdata;
        REG_SP_HI: d.sp[15:8] = reg_wdata;
        default: ;
      endcase
    end
    if (insn_cli) d.gie = 1'b0;
    if (insn_sei) d.gie = 1'b1;
    // an instruction completing clears the one-instruction hold
    if (insn_boundary && q.st == ST_RUN) d.hold_one = 1'b0;
    if (insn_sei) d.hold_one = 1'b1;
    // status register is never saved or restored here
    case (q.st)
      ST_RUN: begin
        if (q.reset_vec) begin
          d.reset_vec = 1'b0;
          d.vvalid = 1'b1;
          d.idx = 8'h00;
          d.vaddr = boot_reset_vector_fuse ? BOOT_START : '0;
        end else if (insn_return_from_interrupt && q.st == ST_RUN) begin
          d.st = ST_RETURN;
          d.cnt = 3'd0;
        end else if (can_take) begin
          d.idx = win;
          d.ret_pc = program_counter;
          d.gie = 1'b0;
          d.cnt = 3'd0;
          if (!LEVEL_TYPE[win-1]) d.flg[win-1] = 1'b0;
          d.st = core_sleeping ? ST_WAKE : ST_ENTRY;
        end
      end
      ST_WAKE: begin
        // extra cycles count only after the start-up time has passed
        if (wake_ready) begin
          d.cnt = q.cnt + 3'd1;
          if (q.cnt == 3'(WAKE_EXTRA_CYCLES - 1)) begin
            d.cnt = 3'd0;
            d.st = ST_ENTRY;
          end
        end
      end
      ST_ENTRY: begin
        d.cnt = q.cnt + 3'd1;
        if (q.cnt < 3'(PC_BYTES)) d.sp = q.sp - 1'b1;
        if (q.cnt == 3'(ENTRY_CYCLES - 1)) begin
          d.st = ST_RUN;
          d.vvalid = 1'b1;
          // each vector is two words apart from the next
          d.vaddr = vec_base + PC_W'(q.idx) * PC_W'(VEC_STEP);
        end
      end
      ST_RETURN: begin
        d.cnt = q.cnt + 3'd1;
        if (q.cnt < 3'(PC_BYTES)) begin
          d.sp = q.sp + 1'b1;
          d.popped = {q.popped[7:0], stack_rdata};
        end
        if (q.cnt == 3'(RETURN_CYCLES - 1)) begin
          d.st = ST_RUN;
          d.gie = 1'b1;
          d.hold_one = 1'b1;
          d.vaddr = q.popped;
          d.vvalid = 1'b1;
        end
      end
      default: d.st = ST_RUN;
    endcase
    // read data, one cycle after the strobe
    d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: d.rdata = {q.gie, 7'h00};
        REG_PROC_CTRL: d.rdata = 8'({q.vector_relocate_select, 1'b0});
        REG_ENABLE: d.rdata = 8'(q.en);
        REG_FLAGS: d.rdata = 8'(q.flg);
        REG_SP_LO: d.rdata = q.sp[7:0];
        REG_SP_HI: d.rdata = q.sp[15:8];
        REG_STATE: d.rdata = {q.idx[5:0], q.st};
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= ST_RUN;
      q.sp <= SP_RESET;
      q.reset_vec <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign reg_rdata = q.rdata;
  assign core_stall = q.st != ST_RUN;
  assign vector_valid = q.vvalid;
  assign vector_addr = q.vaddr;
  assign vector_index = q.idx;
  assign pc_load = q.vvalid;
  assign pc_load_value = q.vaddr;
  // push low byte first, pointer post-decrement; pop pre-increment
  assign stack_wr = q.st == ST_ENTRY && q.cnt < 3'(PC_BYTES);
  assign stack_rd = q.st == ST_RETURN && q.cnt < 3'(PC_BYTES);
  assign stack_addr = q.st == ST_RETURN ? q.sp + 1'b1 : q.sp;
  always_comb begin
    case (q.cnt)
      3'd0: stack_wdata = q.ret_pc[7:0];
      3'd1: stack_wdata = q.ret_pc[15:8];
      default: stack_wdata = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

/* File: sim/cis_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker for the interrupt sequencer
// ****************************************
module cis_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic insn_cli,
  input wire logic insn_sei,
  input wire logic core_stall,
  input wire logic vector_valid,
  input wire logic pc_load,
  input wire logic [15:0] vector_addr,
  input wire logic [15:0] pc_load_value,
  input wire logic stack_wr,
  input wire logic stack_rd,
  input wire logic [15:0] stack_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // entry: three pushes, stall, vector five cycles after first push
  a_entry_time: assert property (
    $rose(stack_wr) |-> ##5 vector_valid) else $error("late vector");
  a_push_three: assert property (
    $rose(stack_wr) |-> stack_wr [*3] ##1 !stack_wr) else $error("push count");
  a_stall_entry: assert property (
    $rose(stack_wr) |-> core_stall [*5]) else $error("no stall");
  // stack pointer direction on push and pop
  a_push_down: assert property (
    stack_wr && $past(stack_wr) |-> stack_addr == $past(stack_addr) - 16'h1)
    else $error("push addr");
  a_pop_up: assert property (
    stack_rd && $past(stack_rd) |-> stack_addr == $past(stack_addr) + 16'h1)
    else $error("pop addr");
  a_pop_three: assert property (
    $rose(stack_rd) |-> stack_rd [*3] ##1 !stack_rd) else $error("pop count");
  a_ret_vector: assert property (
    $fell(stack_rd) |-> ##[0:3] vector_valid) else $error("no return vector");
  // no entry launched from a clear or set instruction cycle
  a_cli_block: assert property (
    insn_cli && !core_stall |=> !stack_wr) else $error("taken after clear");
  a_sei_defer: assert property (
    insn_sei && !core_stall |=> !stack_wr) else $error("taken after set");
  // fetch load and read port idle value
  a_vec_pair: assert property (
    vector_valid |-> pc_load && vector_addr == pc_load_value)
    else $error("load mismatch");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
endmodule
`default_nettype wire

/* File: sim/cis_stack_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// data memory behind the stack port
// ****************************************
module cis_stack_model (
  input wire logic clk,
  input wire logic stack_wr,
  input wire logic stack_rd,
  input wire logic [15:0] stack_addr,
  input wire logic [7:0] stack_wdata,
  output logic [7:0] stack_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] ptn_q = 8'h5a;
  // store pushed bytes, churn the idle pattern
  always_ff @(posedge clk) begin
    if (stack_wr) mem[stack_addr] <= stack_wdata;
    ptn_q <= ptn_q + 8'h3b;
  end
  // data only while popping, otherwise a moving pattern
  assign stack_rdata = stack_rd ? mem[stack_addr] : ptn_q;
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// sequencer bench
// ****************************************
module testbench;
  import cis_pkg::*;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, src_event = 8'h00;
  logic insn_boundary = 1'b0, insn_cli = 1'b0;
  logic insn_sei = 1'b0, insn_return_from_interrupt = 1'b0;
  logic fuse = 1'b0, app_lock = 1'b0, sleeping = 1'b0;
  logic [15:0] pc = 16'h0123, bss = BOOT_START_DEF;
  logic [7:0] reg_rdata, stack_wdata, stack_rdata, vector_index;
  logic core_stall, vector_valid, stack_wr, stack_rd;
  logic [15:0] vector_addr, stack_addr;
  int errors = 0, cmp_count = 0;
  cis_sequencer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_event(src_event),
    .insn_boundary(insn_boundary), .insn_cli(insn_cli),
    .insn_sei(insn_sei), .insn_return_from_interrupt(insn_return_from_interrupt), .core_sleeping(sleeping),
    .wake_ready(1'b1), .program_counter(pc), .boot_section_start(bss),
    .boot_reset_vector_fuse(fuse), .app_section_lock_bit(app_lock),
    .boot_section_lock_bit(1'b0), .core_stall(core_stall),
    .vector_valid(vector_valid), .vector_addr(vector_addr),
    .vector_index(vector_index), .stack_wr(stack_wr), .stack_rd(stack_rd),
    .stack_addr(stack_addr), .stack_wdata(stack_wdata),
    .stack_rdata(stack_rdata), .pc_load(), .pc_load_value());
  cis_stack_model u_mem (.clk(clk), .stack_wr(stack_wr),
    .stack_rd(stack_rd), .stack_addr(stack_addr),
    .stack_wdata(stack_wdata), .stack_rdata(stack_rdata));
  // clock
  initial begin
    forever #5 clk = ~clk;
  end
  // compare and verdict
  task chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // register port cycles
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // core side helpers
  task bnd;
    @(posedge clk) insn_boundary <= 1'b1;
    @(posedge clk) insn_boundary <= 1'b0;
    #1;
  endtask
  task evt(input logic [7:0] v);
    @(posedge clk) src_event <= v;
    @(posedge clk) src_event <= 8'h00;
  endtask
  task wait_vec;
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (vector_valid === 1'b1) break;
    end
    if (i == 40) begin
      errors++;
      final_report();
    end
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_vec();
    chk(vector_addr, 16'h0000);
    chk(vector_index, 16'h0000);
    rd(REG_STATUS, 8'h00);
    rd(REG_SP_LO, 8'hff);
    rd(REG_SP_HI, 8'h10);
    rd(4'hf, 8'h00);
    evt(8'h24);
    rd(REG_FLAGS, 8'h24);
    wr(REG_FLAGS, 8'h00);
    rd(REG_FLAGS, 8'h24);
    wr(REG_FLAGS, 8'h20);
    rd(REG_FLAGS, 8'h04);
    evt(8'h20);
    wr(REG_ENABLE, 8'h24);
    rd(REG_ENABLE, 8'h24);
    @(posedge clk) insn_cli <= 1'b1;
    @(posedge clk) insn_cli <= 1'b0;
    bnd();
    chk(core_stall, 1'b0);
    @(posedge clk) insn_sei <= 1'b1;
    @(posedge clk) insn_sei <= 1'b0;
    bnd();
    chk(core_stall, 1'b0);
    bnd();
    wait_vec();
    chk(vector_index, 16'h0003);
    chk(vector_addr, 16'h0006);
    chk(u_mem.mem[16'h10ff], 16'h0023);
    chk(u_mem.mem[16'h10fe], 16'h0001);
    rd(REG_STATUS, 8'h00);
    rd(REG_FLAGS, 8'h20);
    rd(REG_SP_LO, 8'hfc);
    @(posedge clk) insn_return_from_interrupt <= 1'b1;
    @(posedge clk) insn_return_from_interrupt <= 1'b0;
    wait_vec();
    chk(vector_addr, 16'h0123);
    rd(REG_STATUS, 8'h80);
    rd(REG_SP_LO, 8'hff);
    wr(REG_PROC_CTRL, 8'h02);
    bnd();
    chk(core_stall, 1'b0);
    bnd();
    wait_vec();
    chk(vector_index, 16'h0006);
    chk(vector_addr, 16'hf00c);
    // mid-run reset with the boot reset fuse programmed
    @(posedge clk) begin
      rst <= 1'b1;
      fuse <= 1'b1;
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_vec();
    chk(vector_addr, BOOT_START_DEF);
    // lock bit of the application section blocks the request
    wr(REG_ENABLE, 8'h01);
    wr(REG_STATUS, 8'h80);
    @(posedge clk) app_lock <= 1'b1;
    evt(8'h01);
    bnd();
    chk(core_stall, 1'b0);
    // taken while asleep: five wake cycles before the entry
    @(posedge clk) begin
      app_lock <= 1'b0;
      sleeping <= 1'b1;
    end
    bnd();
    repeat (9) @(posedge clk);
    #1 chk(vector_valid, 1'b0);
    @(posedge clk);
    #1 chk(vector_valid, 1'b1);
    chk(vector_index, 16'h0001);
    final_report();
  end
endmodule
bind cis_sequencer cis_props u_props (.clk(clk), .rst(rst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .insn_cli(insn_cli),
  .insn_sei(insn_sei), .core_stall(core_stall),
  .vector_valid(vector_valid), .pc_load(pc_load),
  .vector_addr(vector_addr), .pc_load_value(pc_load_value),
  .stack_wr(stack_wr), .stack_rd(stack_rd), .stack_addr(stack_addr));
`default_nettype wire
